// ==== pkg/lvt_pkg.sv ====
// Purpose: shared constants for the four-lane 7:1 training link
// Assumes: one fabric clock; serial rates are enables derived from it
// Notes: codes are seven bits, sent most significant bit first
package lvt_pkg;

   localparam int LANES = 4;
   localparam int WORD_BITS = 7;

   // Reference and serial timing
   localparam int REF_CLK_HZ = 50_000_000;
   localparam int BIT_DIV = 2;
   localparam int DIV_W = 2;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);
   localparam logic [2:0] BIT_LAST = 3'(WORD_BITS - 1);

   // Training codes and forwarded clock shape
   localparam logic [6:0] PHASE_CODE = 7'h78;
   localparam logic [6:0] WORD_CODE = 7'h55;
   localparam logic [6:0] FWD_CLK_PATTERN = 7'h63;

   // Register map of the receiving controller
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0c;
   localparam int BIT_ALIGNED = 0;
   localparam int BIT_MATCH = 1;
   localparam int BIT_MISMATCH = 1;
   localparam int BIT_RETRAIN = 0;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

   typedef enum logic [1:0] {
      LVT_TX_PHASE = 2'b00,
      LVT_TX_WORD = 2'b01,
      LVT_TX_DATA = 2'b10
   } lvt_tx_state_type;

   typedef enum logic [1:0] {
      LVT_RX_PHASE = 2'b00,
      LVT_RX_WORD = 2'b01,
      LVT_RX_LOCK = 2'b10
   } lvt_rx_state_type;

endpackage : lvt_pkg

// ==== pkg/lvt_link_if.sv ====
// Purpose: the wires between the pattern source and the aligner
// Assumes: both ends run on the same fabric clock
// Notes: pairs are carried as p and n levels; no tristate pins
`timescale 1ns/1ns
interface lvt_link_if;
   logic fwd_clk_p;
   logic fwd_clk_n;
   logic [3:0] lane_p;
   logic [3:0] lane_n;
   logic fast_serial_clock;
   logic phase_aligned;
   logic fifo_rd_en;

   modport tx (
      output fwd_clk_p,
      output fwd_clk_n,
      output lane_p,
      output lane_n,
      output fast_serial_clock,
      input phase_aligned,
      input fifo_rd_en
   );

   modport rx (
      input fwd_clk_p,
      input fwd_clk_n,
      input lane_p,
      input lane_n,
      input fast_serial_clock,
      output phase_aligned,
      output fifo_rd_en
   );
endinterface : lvt_link_if

// ==== logic/lvt_tx.sv ====
// Purpose: pattern source and 7:1 serializer for four lanes plus clock
// Assumes: pclk is the 50 MHz reference input; link partner shares it
// Notes: one bit slot per BIT_DIV cycles of pclk
`timescale 1ns/1ns
module lvt_tx
   import lvt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic gen_enable,
   lvt_link_if.tx link,
   output logic tx_sending,
   output logic [1:0] tx_mode
);

   logic [DIV_W-1:0] div_cnt;
   logic serial_bit_clock;
   logic [2:0] bit_idx;
   logic word_load;
   lvt_tx_state_type state;
   lvt_tx_state_type next_state;
   logic [6:0] data_cnt;
   // Word each lane will carry next; read only in a word-load cycle
   logic [6:0] next_word [LANES];
   logic [6:0] lane_shift [LANES];
   logic [2:0] next_bit_idx;

   // Bit slot enable from the reference; the divider stalls when disabled
   // With BIT_DIV of two a seven-bit word takes fourteen reference cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= '0;
      end else if (gen_enable) begin
         if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
         end else begin
            div_cnt <= div_cnt + DIV_W'(1);
         end
      end
   end

   // Gated here too, so a disable in mid-slot cannot let one more bit out
   assign serial_bit_clock = gen_enable && (div_cnt == DIV_LAST);

   // Position of the bit now on the pins; starts at the last slot so that
   // the very first enable loads a fresh word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_idx <= BIT_LAST;
      end else if (serial_bit_clock) begin
         bit_idx <= next_bit_idx;
      end
   end

   // Slot counter wraps after the seventh bit of each word
   assign next_bit_idx = (bit_idx == BIT_LAST) ? 3'h0 : bit_idx + 3'h1;
   assign word_load = serial_bit_clock && (bit_idx == BIT_LAST);

   // Serial clock flips once per bit, so two bits ride on each of its
   // periods and 3.5 periods fit in one seven-bit word
   // It freezes at its level while generation is disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.fast_serial_clock <= 1'b0;
      end else if (serial_bit_clock) begin
         link.fast_serial_clock <= ~link.fast_serial_clock;
      end
   end

   // Training sequence; changes only on word boundaries so no word is torn
   // Losing either flag from the far end sends training back to its start
   always_comb begin
      next_state = state;
      unique case (state)
         LVT_TX_PHASE: begin
            if (link.phase_aligned) begin
               next_state = LVT_TX_WORD;
            end
         end
         LVT_TX_WORD: begin
            if (!link.phase_aligned) begin
               next_state = LVT_TX_PHASE;
            end else if (link.fifo_rd_en) begin
               next_state = LVT_TX_DATA;
            end
         end
         LVT_TX_DATA: begin
            if (!link.phase_aligned || !link.fifo_rd_en) begin
               next_state = LVT_TX_PHASE;
            end
         end
         default: begin
            next_state = LVT_TX_PHASE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LVT_TX_PHASE;
      end else if (word_load) begin
         // Moving only at a load keeps state in step with the pins
         state <= next_state;
      end
   end

   // Payload counter; restarts at zero each time payload begins
   // Seven bits wide so that it wraps together with the lane word
   // The far end counts the same way, so a wrap is not a mismatch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_cnt <= '0;
      end else if (word_load) begin
         if (next_state == LVT_TX_DATA) begin
            data_cnt <= data_cnt + 7'h1;
         end else begin
            data_cnt <= '0;
         end
      end
   end

   // Lane k carries counter plus k so that swapped lanes are caught
   // Training codes are the same on every lane; only payload differs
   always_comb begin
      for (int k = 0; k < LANES; k++) begin
         unique case (next_state)
            LVT_TX_PHASE: next_word[k] = PHASE_CODE;
            LVT_TX_WORD: next_word[k] = WORD_CODE;
            LVT_TX_DATA: next_word[k] = data_cnt + 7'(k);
            default: next_word[k] = PHASE_CODE;
         endcase
      end
   end

   // Serializers, most significant bit first
   // Bit six leaves with the load itself, so only six bits wait here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < LANES; k++) begin
            lane_shift[k] <= '0;
         end
      end else if (word_load) begin
         for (int k = 0; k < LANES; k++) begin
            lane_shift[k] <= {next_word[k][5:0], 1'b0};
         end
      end else if (serial_bit_clock) begin
         for (int k = 0; k < LANES; k++) begin
            lane_shift[k] <= {lane_shift[k][5:0], 1'b0};
         end
      end
   end

   // Pins change with the serial clock flip, on either of its edges
   // The n pin is always the inverse; the receiver reads only the p pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Idle pairs rest with p low and n high
         link.lane_p <= '0;
         link.lane_n <= '1;
      end else if (word_load) begin
         for (int k = 0; k < LANES; k++) begin
            link.lane_p[k] <= next_word[k][6];
            link.lane_n[k] <= ~next_word[k][6];
         end
      end else if (serial_bit_clock) begin
         for (int k = 0; k < LANES; k++) begin
            link.lane_p[k] <= lane_shift[k][6];
            link.lane_n[k] <= ~lane_shift[k][6];
         end
      end
   end

   // Forwarded clock is the seven-slot pattern, one period per word
   // Indexed by the slot about to be shown, so pins and clock move together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.fwd_clk_p <= 1'b0;
         link.fwd_clk_n <= 1'b1;
      end else if (serial_bit_clock) begin
         link.fwd_clk_p <= FWD_CLK_PATTERN[3'(BIT_LAST - next_bit_idx)];
         link.fwd_clk_n <= ~FWD_CLK_PATTERN[3'(BIT_LAST - next_bit_idx)];
      end
   end

   // Status for the user side
   // Mirrors the word being loaded, so it changes only at word boundaries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sending <= 1'b0;
         tx_mode <= LVT_TX_PHASE;
      end else if (word_load) begin
         tx_sending <= (next_state == LVT_TX_DATA);
         tx_mode <= next_state;
      end
   end

endmodule : lvt_tx

// ==== logic/lvt_rx.sv ====
// Purpose: deserializer, bit slip aligner, payload checker and APB status
// Assumes: link pins are synchronous to pclk
// Notes: reads of the interrupt status register clear the sticky interrupt bits
`timescale 1ns/1ns
module lvt_rx
   import lvt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   lvt_link_if.rx link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic training_done,
   output logic match_indicator,
   output logic irq
);

   logic sclk_q;
   logic sample;
   logic [2:0] rx_idx;
   logic slip;
   logic [6:0] rx_shift [LANES];
   logic [6:0] rx_word [LANES];
   logic word_vld;
   logic all_phase;
   logic all_word;
   logic all_ok;
   logic started;
   logic [6:0] expect_cnt;
   lvt_rx_state_type state;
   logic retrain;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic ev_align;
   logic ev_mismatch;
   logic apb_done;

   // Sample on every change of the serial clock, rising or falling
   assign sample = link.fast_serial_clock != sclk_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         rx_idx <= '0;
         word_vld <= 1'b0;
      end else begin
         sclk_q <= link.fast_serial_clock;
         word_vld <= sample && !slip && (rx_idx == BIT_LAST);
         if (sample && !slip) begin
            rx_idx <= (rx_idx == BIT_LAST) ? 3'h0 : rx_idx + 3'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < LANES; k++) begin
            rx_shift[k] <= '0;
            rx_word[k] <= '0;
         end
      end else if (sample) begin
         for (int k = 0; k < LANES; k++) begin
            rx_shift[k] <= {rx_shift[k][5:0], link.lane_p[k]};
            if (!slip && rx_idx == BIT_LAST) begin
               rx_word[k] <= {rx_shift[k][5:0], link.lane_p[k]};
            end
         end
      end
   end

   always_comb begin
      all_phase = 1'b1;
      all_word = 1'b1;
      all_ok = 1'b1;
      for (int k = 0; k < LANES; k++) begin
         all_phase = all_phase && (rx_word[k] == PHASE_CODE);
         all_word = all_word && (rx_word[k] == WORD_CODE);
         all_ok = all_ok && (rx_word[k] == expect_cnt + 7'(k));
      end
   end

   // Alignment sequence; a slip holds the word boundary back one bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LVT_RX_PHASE;
         slip <= 1'b0;
      end else if (retrain) begin
         state <= LVT_RX_PHASE;
         slip <= 1'b0;
      end else begin
         if (sample) begin
            slip <= 1'b0;
         end
         if (word_vld) begin
            unique case (state)
               LVT_RX_PHASE: begin
                  if (all_phase) begin
                     state <= LVT_RX_WORD;
                  end else begin
                     slip <= 1'b1;
                  end
               end
               LVT_RX_WORD: begin
                  if (all_word) begin
                     state <= LVT_RX_LOCK;
                  end else if (!all_phase) begin
                     state <= LVT_RX_PHASE;
                  end
               end
               LVT_RX_LOCK: begin
                  state <= LVT_RX_LOCK;
               end
               default: begin
                  state <= LVT_RX_PHASE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.phase_aligned <= 1'b0;
         link.fifo_rd_en <= 1'b0;
         training_done <= 1'b0;
      end else begin
         link.phase_aligned <= !retrain && (state != LVT_RX_PHASE);
         link.fifo_rd_en <= !retrain && (state == LVT_RX_LOCK);
         training_done <= !retrain && (state == LVT_RX_LOCK);
      end
   end

   // Word codes still in flight are skipped before the first payload word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started <= 1'b0;
         expect_cnt <= '0;
         match_indicator <= 1'b0;
      end else if (state != LVT_RX_LOCK || retrain) begin
         started <= 1'b0;
         expect_cnt <= '0;
         match_indicator <= 1'b0;
      end else if (word_vld && (started || !all_word)) begin
         started <= 1'b1;
         expect_cnt <= expect_cnt + 7'h1;
         match_indicator <= all_ok;
      end
   end

   assign ev_align = word_vld && !retrain && (state == LVT_RX_WORD) && all_word;
   assign ev_mismatch = word_vld && !retrain && (state == LVT_RX_LOCK) && (started || !all_word) && !all_ok;
   assign apb_done = psel && penable && pready;

   // APB slave with one wait state; unmapped offsets answer with an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
         irq_mask <= IRQ_MASK_RESET;
         retrain <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         retrain <= 1'b0;
         if (psel && penable && !pready) begin
            prdata <= '0;
            pslverr <= 1'b0;
            unique case (paddr)
               REG_STATUS: prdata[1:0] <= {match_indicator, training_done};
               REG_IRQ_STATUS: prdata[1:0] <= irq_status;
               REG_IRQ_MASK: prdata[1:0] <= irq_mask;
               REG_CTRL: prdata <= '0;
               default: pslverr <= 1'b1;
            endcase
         end
         if (apb_done && pwrite && paddr == REG_IRQ_MASK) begin
            irq_mask <= pwdata[1:0];
         end
         if (apb_done && pwrite && paddr == REG_CTRL) begin
            retrain <= pwdata[BIT_RETRAIN];
         end
      end
   end

   // Sticky events; a new event wins over the read that clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         irq_status[BIT_ALIGNED] <= ev_align ||
            (irq_status[BIT_ALIGNED] && !(apb_done && !pwrite && paddr == REG_IRQ_STATUS));
         irq_status[BIT_MISMATCH] <= ev_mismatch ||
            (irq_status[BIT_MISMATCH] && !(apb_done && !pwrite && paddr == REG_IRQ_STATUS));
         irq <= |(irq_status & irq_mask);
      end
   end

endmodule : lvt_rx

// ==== sim/lvt_link_sva.sv ====
// Purpose: concurrent checks on the wires between the pattern source and the aligner
// Assumes: one clock domain, presetn asynchronous and active low
// Notes: watches the link interface only; register behaviour is judged by the bench
`timescale 1ns/1ns
module lvt_link_sva
   import lvt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fwd_clk_p,
   input wire logic fwd_clk_n,
   input wire logic [3:0] lane_p,
   input wire logic [3:0] lane_n,
   input wire logic fast_serial_clock,
   input wire logic phase_aligned,
   input wire logic fifo_rd_en
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic fsc_q;
   logic fwd_q;
   logic [3:0] tog_cnt;
   logic [1:0] rises;
   logic ever_rd;
   logic tog;
   logic fwd_rise;

   assign tog = fast_serial_clock != fsc_q;
   assign fwd_rise = fwd_clk_p && !fwd_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsc_q <= 1'b0;
         fwd_q <= 1'b0;
      end else begin
         fsc_q <= fast_serial_clock;
         fwd_q <= fwd_clk_p;
      end
   end

   // The first clock period after reset is short, so only the third rise onward is measured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog_cnt <= 4'h0;
         rises <= 2'h0;
      end else begin
         if (fwd_rise) begin
            tog_cnt <= 4'h1;
         end else if (tog) begin
            tog_cnt <= tog_cnt + 4'h1;
         end
         if (fwd_rise && rises != 2'h2) begin
            rises <= rises + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ever_rd <= 1'b0;
      end else if (fifo_rd_en) begin
         ever_rd <= 1'b1;
      end
   end

   sequence slot_start;
      $changed(fast_serial_clock);
   endsequence

   sequence phase_held;
      $past(phase_aligned, 8) && $past(phase_aligned);
   endsequence

   AST_LANE_PAIR: assert property (lane_n == ~lane_p)
      else $error("data pair not complementary");
   AST_FWD_PAIR: assert property (fwd_clk_n == ~fwd_clk_p)
      else $error("clock pair not complementary");
   AST_SLOT_SPACING: assert property (slot_start |=> $stable(fast_serial_clock))
      else $error("serial clock toggled in consecutive cycles");
   AST_BIT_ON_EDGE: assert property ($changed(lane_p) |-> slot_start)
      else $error("lane bit changed without a serial clock edge");
   AST_FWD_ON_EDGE: assert property ($changed(fwd_clk_p) |-> slot_start)
      else $error("forwarded clock changed off a bit slot");
   AST_SEVEN_BITS: assert property (fwd_rise && rises == 2'h2 |-> tog_cnt == 4'h7)
      else $error("forwarded clock period is not seven bits");
   AST_TRAIN_LANES_EQ: assert property (!ever_rd |-> lane_p == 4'h0 || lane_p == 4'hf)
      else $error("lanes differ before payload release");
   AST_RDEN_NEEDS_PHASE: assert property (fifo_rd_en |-> phase_aligned)
      else $error("read enable without phase alignment");
   AST_WORD_AFTER_PHASE: assert property ($rose(fifo_rd_en) |-> phase_held)
      else $error("read enable rose too soon after phase alignment");
   AST_RESET_CLEAR: assert property ($rose(presetn) |-> !phase_aligned && !fifo_rd_en && !fast_serial_clock)
      else $error("link outputs not cleared by reset");

   COV_RELEASE: cover property ($rose(fifo_rd_en));
endmodule : lvt_link_sva

// ==== sim/lvds_seven_to_one_link_training_test.sv ====
// Purpose: end-to-end bench of pattern source and aligner joined by the link interface
// Assumes: pclk stands for the reference clock; APB slave answers with one wait state
// Notes: lane words are rebuilt on the falling edge, after each bit slot has settled
`timescale 1ns/1ns
module lvds_seven_to_one_link_training_test
   import lvt_pkg::*;
;
   logic pclk, presetn, gen_enable, psel, penable, pwrite, pready, pslverr, errv;
   logic training_done, match_indicator, irq, tx_sending, fsc_q;
   logic [1:0] tx_mode;
   logic [7:0] paddr, snap;
   logic [31:0] pwdata, prdata, rdv;
   logic [27:0] sh;
   logic [27:0] words[$];
   logic [6:0] fsh;
   int errors, total_checks, nbit;

   lvt_link_if link();
   lvt_tx i_lvt_tx (.pclk(pclk), .presetn(presetn), .gen_enable(gen_enable), .link(link),
      .tx_sending(tx_sending), .tx_mode(tx_mode));
   lvt_rx i_lvt_rx (.pclk(pclk), .presetn(presetn), .link(link), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .training_done(training_done), .match_indicator(match_indicator), .irq(irq));
   lvt_link_sva i_lvt_link_sva (.pclk(pclk), .presetn(presetn), .fwd_clk_p(link.fwd_clk_p),
      .fwd_clk_n(link.fwd_clk_n), .lane_p(link.lane_p), .lane_n(link.lane_n),
      .fast_serial_clock(link.fast_serial_clock), .phase_aligned(link.phase_aligned), .fifo_rd_en(link.fifo_rd_en));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait-state count is assumed; only the watchdog ends a stuck access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, addr, 32'h0);
      check(rdv, exp);
      check(32'(errv), 32'(exp_err));
   endtask : rd_check

   task automatic wait_train(input logic want);
      int n;
      n = 0;
      while (training_done !== want && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      check(32'(training_done), 32'(want));
   endtask : wait_train

   // Words from reset: phase codes, then word codes, then lane k = counter + k
   task automatic check_wire;
      int i;
      i = 0;
      check(32'(words[0]), 32'({4{PHASE_CODE}}));
      while (i < words.size() - 2 && words[i] === {4{PHASE_CODE}}) i++;
      check(32'(words[i]), 32'({4{WORD_CODE}}));
      while (i < words.size() - 2 && words[i] === {4{WORD_CODE}}) i++;
      check(32'(words[i]), {4'h0, 7'h3, 7'h2, 7'h1, 7'h0});
      check(32'(words[i + 1]), {4'h0, 7'h4, 7'h3, 7'h2, 7'h1});
   endtask : check_wire

   always @(negedge pclk) begin
      if (!presetn) begin
         words.delete();
         nbit = 0;
         fsc_q = 1'b0;
      end else if (link.fast_serial_clock !== fsc_q) begin
         fsc_q = link.fast_serial_clock;
         for (int k = 0; k < LANES; k++) sh[k*7 +: 7] = {sh[k*7 +: 6], link.lane_p[k]};
         fsh = {fsh[5:0], link.fwd_clk_p};
         nbit++;
         if (nbit == WORD_BITS) begin
            nbit = 0;
            check(32'(fsh), 32'(FWD_CLK_PATTERN));
            if (words.size() < 64) words.push_back(sh);
         end
      end
   end

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Whole run needs a few hundred cycles; this leaves ample margin
   initial begin
      repeat (40000) @(posedge pclk);
      errors++;
      finish_test();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      gen_enable = 1'b1;
      errors = 0;
      total_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(32'({training_done, match_indicator, link.fifo_rd_en}), 32'h0);
      rd_check(REG_STATUS, 32'h0, 1'b0);
      rd_check(REG_IRQ_MASK, 32'(IRQ_MASK_RESET), 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      check(32'(errv), 32'h1);
      $display("test reset_state done");

      wait_train(1'b1);
      repeat (80) @(posedge pclk);
      check(32'({match_indicator, link.fifo_rd_en, tx_sending}), 32'h7);
      check(32'({irq, tx_mode}), 32'h2);
      rd_check(REG_STATUS, 32'h3, 1'b0);
      rd_check(REG_IRQ_STATUS, 32'h1, 1'b0);
      rd_check(REG_IRQ_STATUS, 32'h0, 1'b0);
      check_wire();
      $display("test training done");

      gen_enable <= 1'b0;
      repeat (3) @(posedge pclk);
      snap = {link.lane_p, link.fwd_clk_p, link.fast_serial_clock, tx_mode};
      repeat (20) @(posedge pclk);
      check(32'({link.lane_p, link.fwd_clk_p, link.fast_serial_clock, tx_mode}), 32'(snap));
      gen_enable <= 1'b1;
      $display("test freeze done");

      apb(1'b1, REG_IRQ_MASK, 32'h3);
      rd_check(REG_IRQ_MASK, 32'h3, 1'b0);
      apb(1'b1, REG_CTRL, 32'h1);
      wait_train(1'b0);
      wait_train(1'b1);
      repeat (3) @(posedge pclk);
      check(32'(irq), 32'h1);
      apb(1'b0, REG_IRQ_STATUS, 32'h0);
      check(32'(rdv[BIT_ALIGNED]), 32'h1);
      repeat (3) @(posedge pclk);
      check(32'(irq), 32'h0);
      rd_check(REG_CTRL, 32'h0, 1'b0);
      $display("test retrain_irq done");

      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check(32'({training_done, match_indicator, irq, link.fifo_rd_en, link.phase_aligned}), 32'h0);
      presetn <= 1'b1;
      wait_train(1'b1);
      repeat (80) @(posedge pclk);
      check_wire();
      $display("test midrun_reset done");
      finish_test();
   end
endmodule : lvds_seven_to_one_link_training_test
